//--- ptu_consts.svh
`ifndef PTU_CONSTS_SVH
`define PTU_CONSTS_SVH

// Register index inside a channel, regAddr[3:0]; regAddr[4] picks the channel
`define PTU_REG_CLK 4'h0
`define PTU_REG_CTL 4'h1
`define PTU_REG_MC 4'h2
`define PTU_REG_TC 4'h3
`define PTU_REG_CS 4'h4
`define PTU_REG_CCCTL0 4'h5
`define PTU_REG_CCCTL1 4'h6
`define PTU_REG_CCR0 4'h7
`define PTU_REG_CCR1 4'h8

// Clock register fields
`define PTU_CLK_SRC_LSB 0
`define PTU_CLK_DIV_LSB 3
`define PTU_CLK_RUN_IN_DEBUG_BIT 7
`define PTU_CLK_RESET 8'h00

// Control register fields
`define PTU_CTL_EN_BIT 0
`define PTU_CTL_PRESET_BIT 1
`define PTU_CTL_RUN_BIT 2
`define PTU_CTL_ONEST_BIT 3
`define PTU_CTL_MODE_LSB 4
`define PTU_CTL_RESET 6'h00

// Compare/capture control fields
`define PTU_CC_SEL_BIT 0
`define PTU_CC_BUF_LSB 1
`define PTU_CC_MT_BIT 4
`define PTU_CC_OMD_LSB 5
`define PTU_CC_INV_BIT 8
`define PTU_CC_TRG_LSB 9
`define PTU_CC_SWTRG_BIT 11
`define PTU_CCCTL_RESET 11'h000

// Clock source codes
`define PTU_SRC_INTERNAL 3'h0
`define PTU_SRC_EXT0 3'h1
`define PTU_SRC_EXT1 3'h2
`define PTU_SRC_EXT0_INV 3'h3
`define PTU_SRC_EXT1_INV 3'h4

// Edges swallowed before the first event count
`define PTU_DUMMY_EDGES 2'h2

`define PTU_MC_RESET 16'hffff

`endif

//--- ptu_pkg.sv
`default_nettype none

package ptu_pkg;

  typedef logic [15:0] ptu_word_t;

  typedef enum logic [1:0]
  {
    PTU_UP,
    PTU_DOWN,
    PTU_UPDOWN,
    PTU_MODE_RSVD
  } ptu_cnt_mode_t;

  typedef enum logic [2:0]
  {
    PTU_OUT_LOW,
    PTU_OUT_SET_MATCH,
    PTU_OUT_TOGGLE,
    PTU_OUT_CLR_MATCH,
    PTU_OUT_RSVD4,
    PTU_OUT_RSVD5,
    PTU_OUT_RSVD6,
    PTU_OUT_RSVD7
  } ptu_out_mode_t;

endpackage : ptu_pkg

`default_nettype wire

//--- ptu_cc.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptu_consts.svh"

module ptu_cc
  import ptu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic active,
  input wire logic countStep,
  input wire logic periodEvt,
  input wire ptu_word_t counterValue,
  input wire logic compareCaptureSelect,
  input wire logic [2:0] compareBufferMode,
  input wire logic waveformSignalSelect,
  input wire logic [2:0] outputGenerationMode,
  input wire logic outputPolarityInvert,
  input wire logic [1:0] captureEdgeSelect,
  input wire logic swTrigger,
  input wire logic ccrWrite,
  input wire ptu_word_t ccrWrData,
  input wire logic partnerMatch,
  input wire logic captureTriggerPinIn,
  output logic matchPulse,
  output ptu_word_t ccValue,
  output logic eventPulse,
  output logic waveOut,
  output logic waveOe
);

  ptu_word_t buf_q;
  ptu_word_t cmp_q;
  logic match_q;
  logic evt_q;
  logic wave_q;
  logic wave_d;
  logic out_q;
  logic oe_q;
  logic pinPrev_q;

  wire logic isCapture = compareCaptureSelect;
  wire logic match = !isCapture && countStep && (counterValue == cmp_q);
  wire logic pinRise = captureTriggerPinIn && !pinPrev_q;
  wire logic pinFall = !captureTriggerPinIn && pinPrev_q;
  wire logic pinTrig = (captureEdgeSelect[0] && pinRise) || (captureEdgeSelect[1] && pinFall);
  wire logic capture = isCapture && active && (pinTrig || swTrigger);
  wire logic waveSrc = waveformSignalSelect ? partnerMatch : match_q;
  // Unbuffered compare takes writes at once, buffered waits for the period end
  wire logic loadCmp = (compareBufferMode == 3'h0) || periodEvt;

  always_comb
  begin
    wave_d = wave_q;
    unique case (ptu_out_mode_t'(outputGenerationMode))
      PTU_OUT_SET_MATCH:
      begin
        if (waveSrc) wave_d = 1'b1;
        else if (periodEvt) wave_d = 1'b0;
      end
      PTU_OUT_TOGGLE:
      begin
        if (waveSrc) wave_d = !wave_q;
      end
      PTU_OUT_CLR_MATCH:
      begin
        if (waveSrc) wave_d = 1'b0;
        else if (periodEvt) wave_d = 1'b1;
      end
      default:
      begin
        wave_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      buf_q <= 16'h0000;
      cmp_q <= 16'h0000;
      match_q <= 1'b0;
      evt_q <= 1'b0;
      wave_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b1; // (R7)
      pinPrev_q <= 1'b0;
    end
    else
    begin
      pinPrev_q <= captureTriggerPinIn;
      if (capture)
        buf_q <= counterValue; // (R4)
      else if (ccrWrite)
        buf_q <= ccrWrData;
      if (loadCmp)
        cmp_q <= buf_q;
      match_q <= match; // (R3)
      evt_q <= match || capture; // (R3) (R4)
      if (active)
        wave_q <= isCapture ? 1'b0 : wave_d;
      // A halted circuit shows its held level; capture role never drives the pin
      out_q <= isCapture ? 1'b0 : ((active ? wave_d : wave_q) ^ outputPolarityInvert); // (R3) (R8)
      oe_q <= !isCapture; // (R7)
    end
  end

  assign matchPulse = match_q;
  assign ccValue = buf_q;
  assign eventPulse = evt_q;
  assign waveOut = out_q;
  assign waveOe = oe_q;

endmodule : ptu_cc

`default_nettype wire

//--- ptu_top.sv
// Operation
// (R1) 16-bit up/down counter, selectable source and divider
// (R2) Up, down, up/down; one-shot or repeat
// (R3) Comparator match raises request and drives waveform
// (R4) Capture latches counter on trigger, raises request
// (R5) Architecture allows up to six circuits
// (R6) Two channels, two circuits, pin pairs each
// (R7) Shared pin: waveform out or capture in
// (R8) Sleep clock stop halts, keeping all state
// (R9) Debug without run bit suspends the channel
// (R10) Debug with run bit keeps channel running
// (R11) External pin source counts rising edges
// (R12) Inverted external source counts falling edges
// (R13) Two dummy edges precede first event count
// (R14) Software enables source, then selects clock
// (R15) Software enables unit before circuit setup
// (R16) Comparator use: select bit 0, buffer mode
// (R17) Pair circuits configured independently
// (R18) Software picks signal, output mode, polarity
// (R19) Software programs maximum count register
// (R20) Counter reset: zero, or maximum when down
// (R21) Disabled unit holds state, ignores clocks
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_consts.svh"

module ptu_top
  import ptu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] regAddr,
  input wire ptu_word_t regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output ptu_word_t regRdData,
  input wire logic sleepMode,
  input wire logic sleepClockStop,
  input wire logic debugMode,
  input wire logic [3:0] extCountClockPin,
  input wire logic [3:0] captureTriggerPinIn,
  output logic [3:0] timerWaveformPinOut,
  output logic [3:0] timerWaveformPinOe,
  output logic [3:0] ccEvent
);

  localparam int NUM_CH = 2; // (R6)
  localparam int NUM_CC = 2; // (R5) (R6)

  function automatic logic regHit(input logic [4:0] addr, input int ch, input logic [3:0] idx);
    regHit = (addr[4] == ch[0]) && (addr[3:0] == idx);
  endfunction : regHit

  function automatic ptu_word_t divMask(input logic [3:0] div);
    divMask = ptu_word_t'((17'h00001 << div) - 17'h00001);
  endfunction : divMask

  ptu_word_t chRd [NUM_CH];
  ptu_word_t rdData_q;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [7:0] clkReg_q;
    logic [5:0] ctlReg_q;
    ptu_word_t mc_q;
    ptu_word_t cnt_q;
    ptu_word_t cnt_d;
    logic up_q;
    logic up_d;
    logic run_d;
    logic stop;
    logic wrap;
    ptu_word_t pre_q;
    logic [1:0] extPrev_q;
    logic [1:0] dummy_q;
    logic [10:0] ccCtl_q [NUM_CC];
    logic [NUM_CC-1:0] ccMatch;
    ptu_word_t ccVal [NUM_CC];

    wire logic [2:0] srcSel = clkReg_q[`PTU_CLK_SRC_LSB +: 3];
    wire logic [3:0] divSel = clkReg_q[`PTU_CLK_DIV_LSB +: 4];
    wire logic runInDebug = clkReg_q[`PTU_CLK_RUN_IN_DEBUG_BIT];
    wire logic unitEnable = ctlReg_q[`PTU_CTL_EN_BIT];
    wire logic running = ctlReg_q[`PTU_CTL_RUN_BIT];
    wire logic oneShot = ctlReg_q[`PTU_CTL_ONEST_BIT];
    wire ptu_cnt_mode_t cntMode = ptu_cnt_mode_t'(ctlReg_q[`PTU_CTL_MODE_LSB +: 2]);

    wire logic wrClk = regWrStb && regHit(regAddr, c, `PTU_REG_CLK);
    wire logic wrCtl = regWrStb && regHit(regAddr, c, `PTU_REG_CTL);
    wire logic wrMc = regWrStb && regHit(regAddr, c, `PTU_REG_MC);
    wire logic presetReq = wrCtl && regWrData[`PTU_CTL_PRESET_BIT];

    // Operating clock gate: sleep stop and debug suspend freeze the channel in place
    wire logic sleepHalt = sleepMode && sleepClockStop; // (R8)
    wire logic debugHalt = debugMode && !runInDebug; // (R9) (R10)
    wire logic clkOn = !sleepHalt && !debugHalt;
    wire logic active = clkOn && unitEnable; // (R21)

    // External event source; the inverted choices count falling edges
    wire logic isExt = (srcSel >= `PTU_SRC_EXT0) && (srcSel <= `PTU_SRC_EXT1_INV);
    wire logic extIdx = (srcSel == `PTU_SRC_EXT1) || (srcSel == `PTU_SRC_EXT1_INV);
    wire logic extInv = (srcSel == `PTU_SRC_EXT0_INV) || (srcSel == `PTU_SRC_EXT1_INV);
    wire logic extNow = extCountClockPin[c*2 + int'(extIdx)] ^ extInv;
    wire logic extPrev = extPrev_q[extIdx] ^ extInv;
    wire logic extEdge = extNow && !extPrev; // (R11) (R12)
    wire logic dummyDone = (dummy_q == `PTU_DUMMY_EDGES);
    wire ptu_word_t mask = divMask(divSel);
    wire logic divTick = ((pre_q & mask) == mask);
    wire logic srcTick = isExt ? (extEdge && dummyDone) : divTick; // (R1) (R13)
    wire logic tick = active && running && srcTick; // (R21)

    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        clkReg_q <= `PTU_CLK_RESET;
        mc_q <= `PTU_MC_RESET;
      end
      else
      begin
        if (wrClk)
          clkReg_q <= regWrData[7:0];
        if (wrMc)
          mc_q <= regWrData;
      end
    end

    // Prescaler and event edge history only move while the channel is clocked
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        pre_q <= 16'h0000;
        extPrev_q <= 2'h0;
        dummy_q <= 2'h0;
      end
      else
      begin
        if (active)
        begin
          pre_q <= pre_q + 16'h0001; // (R1)
          extPrev_q <= extCountClockPin[c*2 +: 2];
        end
        // A clock change restarts the dummy count even while the channel is halted
        if (!running || wrClk)
          dummy_q <= 2'h0;
        else if (active && isExt && extEdge && !dummyDone)
          dummy_q <= dummy_q + 2'h1; // (R13)
      end
    end

    // Counter stepping; a max below the count restarts an up count at zero
    always_comb
    begin
      cnt_d = cnt_q;
      up_d = up_q;
      stop = 1'b0;
      wrap = 1'b0;
      unique case (cntMode)
        PTU_DOWN:
        begin
          up_d = 1'b0;
          if (cnt_q == 16'h0000)
          begin
            cnt_d = mc_q;
            wrap = 1'b1;
            stop = oneShot;
          end
          else
            cnt_d = cnt_q - 16'h0001;
        end
        PTU_UPDOWN:
        begin
          if (up_q)
          begin
            if (cnt_q > mc_q)
              cnt_d = 16'h0000;
            else if (cnt_q == mc_q)
            begin
              up_d = 1'b0;
              wrap = 1'b1;
              cnt_d = (mc_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
            end
            else
              cnt_d = cnt_q + 16'h0001;
          end
          else if (cnt_q == 16'h0000)
          begin
            up_d = 1'b1;
            stop = oneShot;
            cnt_d = oneShot ? 16'h0000 : 16'h0001;
          end
          else
            cnt_d = cnt_q - 16'h0001;
        end
        default:
        begin
          up_d = 1'b1;
          if (cnt_q >= mc_q)
          begin
            cnt_d = 16'h0000;
            wrap = 1'b1;
            stop = oneShot;
          end
          else
            cnt_d = cnt_q + 16'h0001;
        end
      endcase
    end // (R2)

    assign run_d = wrCtl ? regWrData[`PTU_CTL_RUN_BIT] : (running && !(tick && stop));

    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        ctlReg_q <= `PTU_CTL_RESET;
        cnt_q <= 16'h0000;
        up_q <= 1'b1;
      end
      else
      begin
        ctlReg_q <= wrCtl ? regWrData[5:0] : ctlReg_q;
        ctlReg_q[`PTU_CTL_PRESET_BIT] <= 1'b0;
        ctlReg_q[`PTU_CTL_RUN_BIT] <= run_d; // (R2)
        if (presetReq)
        begin
          cnt_q <= (regWrData[`PTU_CTL_MODE_LSB +: 2] == 2'h1) ? mc_q : 16'h0000; // (R20)
          up_q <= (regWrData[`PTU_CTL_MODE_LSB +: 2] != 2'h1);
        end
        else if (tick)
        begin
          cnt_q <= cnt_d; // (R1) (R21)
          up_q <= up_d;
        end
      end
    end

    for (genvar m = 0; m < NUM_CC; m++)
    begin : g_cc
      wire logic wrCcCtl = regWrStb && regHit(regAddr, c, `PTU_REG_CCCTL0 + 4'(m));
      wire logic wrCcr = regWrStb && regHit(regAddr, c, `PTU_REG_CCR0 + 4'(m));
      wire logic swTrig = wrCcCtl && regWrData[`PTU_CC_SWTRG_BIT];

      // Each circuit keeps its own control word, so a pair may split roles
      always_ff @(posedge sys_clk)
      begin
        if (reset)
          ccCtl_q[m] <= `PTU_CCCTL_RESET;
        else if (wrCcCtl)
          ccCtl_q[m] <= regWrData[10:0]; // (R17)
      end

      ptu_cc u_cc
      (
        .sys_clk(sys_clk),
        .reset(reset),
        .active(active),
        .countStep(tick),
        .periodEvt(tick && wrap),
        .counterValue(cnt_q),
        .compareCaptureSelect(ccCtl_q[m][`PTU_CC_SEL_BIT]),
        .compareBufferMode(ccCtl_q[m][`PTU_CC_BUF_LSB +: 3]),
        .waveformSignalSelect(ccCtl_q[m][`PTU_CC_MT_BIT]),
        .outputGenerationMode(ccCtl_q[m][`PTU_CC_OMD_LSB +: 3]),
        .outputPolarityInvert(ccCtl_q[m][`PTU_CC_INV_BIT]),
        .captureEdgeSelect(ccCtl_q[m][`PTU_CC_TRG_LSB +: 2]),
        .swTrigger(swTrig),
        .ccrWrite(wrCcr),
        .ccrWrData(regWrData),
        .partnerMatch(ccMatch[1 - m]),
        .captureTriggerPinIn(captureTriggerPinIn[c*2 + m]),
        .matchPulse(ccMatch[m]),
        .ccValue(ccVal[m]),
        .eventPulse(ccEvent[c*2 + m]), // (R3) (R4)
        .waveOut(timerWaveformPinOut[c*2 + m]), // (R7)
        .waveOe(timerWaveformPinOe[c*2 + m])
      );
    end

    // Channel read word; unmapped indexes read zero
    always_comb
    begin
      unique case (regAddr[3:0])
        `PTU_REG_CLK: chRd[c] = {8'h00, clkReg_q};
        `PTU_REG_CTL: chRd[c] = {10'h000, ctlReg_q};
        `PTU_REG_MC: chRd[c] = mc_q;
        `PTU_REG_TC: chRd[c] = cnt_q;
        `PTU_REG_CS: chRd[c] = {14'h0000, up_q, running};
        `PTU_REG_CCCTL0: chRd[c] = {5'h00, ccCtl_q[0]};
        `PTU_REG_CCCTL1: chRd[c] = {5'h00, ccCtl_q[1]};
        `PTU_REG_CCR0: chRd[c] = ccVal[0];
        `PTU_REG_CCR1: chRd[c] = ccVal[1];
        default: chRd[c] = 16'h0000;
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rdData_q <= 16'h0000;
    else
      rdData_q <= regRdStb ? chRd[regAddr[4]] : 16'h0000;
  end

  assign regRdData = rdData_q;

endmodule : ptu_top

`default_nettype wire

//--- ptu_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module ptu_top_asserts
  import ptu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] regAddr,
  input wire ptu_word_t regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire ptu_word_t regRdData,
  input wire logic sleepMode,
  input wire logic sleepClockStop,
  input wire logic debugMode,
  input wire logic [3:0] timerWaveformPinOut,
  input wire logic [3:0] timerWaveformPinOe,
  input wire logic [3:0] ccEvent
);
  logic enableQ;
  logic debugRunQ;
  logic capSelQ;
  wire logic halted = sleepMode && sleepClockStop;

  // Channel 0 bits rebuilt from bus writes, since only ports are visible here
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      enableQ <= 1'b0;
      debugRunQ <= 1'b0;
      capSelQ <= 1'b0;
    end
    else
    begin
      if (regWrStb && regAddr == 5'h01)
        enableQ <= regWrData[0];
      if (regWrStb && regAddr == 5'h00)
        debugRunQ <= regWrData[7];
      if (regWrStb && regAddr == 5'h06)
        capSelQ <= regWrData[0];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence haltRun;
    (halted && !regWrStb)[*3];
  endsequence
  sequence swCapture;
    regWrStb && regAddr == 5'h06 && regWrData[0] && regWrData[11];
  endsequence

  a_reset_pins_low:
    assert property (disable iff (1'b0) reset |=> timerWaveformPinOut == 4'h0
      && timerWaveformPinOe == 4'hf && ccEvent == 4'h0)
      else $error("pins not low outputs after reset");
  a_capture_pin_quiet:
    assert property ((~timerWaveformPinOe & timerWaveformPinOut) == 4'h0)
      else $error("pin level driven in capture role");
  a_read_idle_zero:
    assert property (!regRdStb |=> regRdData == 16'h0000)
      else $error("read data not zero outside read cycle");
  a_unmapped_read_zero:
    assert property (regRdStb && regAddr[3:0] > 4'h8 |=> regRdData == 16'h0000)
      else $error("unmapped index read not zero");
  a_preset_reads_zero:
    assert property (regRdStb && regAddr[3:0] == 4'h1 |=> regRdData[15:6] == 10'h000
      && !regRdData[1])
      else $error("control read shows preset or spare bits");
  a_halt_no_event:
    assert property (halted[*3] |-> ccEvent == 4'h0)
      else $error("request while clock stopped in sleep");
  a_halt_wave_hold:
    assert property (haltRun |-> $stable(timerWaveformPinOut))
      else $error("waveform moved while clock stopped");
  a_debug_no_event:
    assert property ((debugMode && !debugRunQ)[*3] |-> ccEvent[1:0] == 2'h0)
      else $error("channel 0 request in debug halt");
  // A trigger only counts once the circuit already sits in capture role
  a_swtrig_capture:
    assert property (swCapture ##0 (enableQ && capSelQ && !halted && !debugMode)
      |-> ##[1:3] ccEvent[1])
      else $error("software capture raised no request");
  a_role_capture_oe:
    assert property (regWrStb && regAddr == 5'h06 && regWrData[0] |-> ##2 !timerWaveformPinOe[1])
      else $error("capture role pin still driven");
  a_role_compare_oe:
    assert property (regWrStb && regAddr == 5'h05 && !regWrData[0] |-> ##2 timerWaveformPinOe[0])
      else $error("comparator role pin not driven");
endmodule : ptu_top_asserts

bind ptu_top ptu_top_asserts i_asserts (.sys_clk, .reset, .regAddr, .regWrData, .regWrStb,
  .regRdStb, .regRdData, .sleepMode, .sleepClockStop, .debugMode, .timerWaveformPinOut,
  .timerWaveformPinOe, .ccEvent);

`default_nettype wire

//--- ptu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module ptu_pin_model
(
  input wire logic [3:0] extLevel,
  input wire logic [3:0] capLevel,
  input wire logic [3:0] waveOut,
  input wire logic [3:0] waveOe,
  output logic [3:0] extPin,
  output logic [3:0] capPin
);
  // Event source stands still between requested edges, dummies included
  assign extPin = extLevel;
  // Shared pin: device drives it in comparator role, trigger source otherwise
  assign capPin = (waveOe & waveOut) | (~waveOe & capLevel);
endmodule : ptu_pin_model

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ptu_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] regAddr = 5'h00;
  ptu_word_t regWrData = 16'h0000;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  ptu_word_t regRdData;
  logic sleepMode = 1'b0;
  logic sleepClockStop = 1'b0;
  logic debugMode = 1'b0;
  logic [3:0] extLevel = 4'h0;
  logic [3:0] capLevel = 4'h0;
  logic [3:0] extCountClockPin;
  logic [3:0] captureTriggerPinIn;
  logic [3:0] timerWaveformPinOut;
  logic [3:0] timerWaveformPinOe;
  logic [3:0] ccEvent;
  int evCnt [4] = '{0, 0, 0, 0};
  int mismatches = 0;
  int nChecks = 0;

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  ptu_top i_dut (.sys_clk, .reset, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .sleepMode, .sleepClockStop, .debugMode, .extCountClockPin, .captureTriggerPinIn,
    .timerWaveformPinOut, .timerWaveformPinOe, .ccEvent);
  ptu_pin_model i_pins (.extLevel, .capLevel, .waveOut(timerWaveformPinOut),
    .waveOe(timerWaveformPinOe), .extPin(extCountClockPin), .capPin(captureTriggerPinIn));

  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
      evCnt[i] += int'(ccEvent[i] === 1'b1);
  end

  task automatic check(input string what, input ptu_word_t exp, input ptu_word_t got);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input ptu_word_t d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [4:0] a, input ptu_word_t exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    check($sformatf("register %h", a), exp, regRdData);
  endtask : rd

  task automatic lvl(input logic v);
    @(posedge sys_clk);
    extLevel[0] <= v;
    repeat (3) @(posedge sys_clk);
  endtask : lvl

  task automatic pulse(input int n);
    repeat (n)
    begin
      lvl(1'b1);
      lvl(1'b0);
    end
  endtask : pulse

  task automatic end_of_test;
    if (mismatches == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(5'h00, 16'h0000);
    rd(5'h01, 16'h0000);
    rd(5'h02, 16'hffff);
    rd(5'h12, 16'hffff);
    rd(5'h05, 16'h0000);
    rd(5'h09, 16'h0000);
    check("pin oe", 16'h000f, {12'h000, timerWaveformPinOe});
    wr(5'h00, 16'h0001);
    wr(5'h01, 16'h0001);
    wr(5'h05, 16'h0020);
    wr(5'h06, 16'h0201);
    wr(5'h07, 16'h0002);
    wr(5'h02, 16'h0007);
    wr(5'h01, 16'h0007);
    pulse(5);
    rd(5'h03, 16'h0003);
    check("compare events", 16'h0001, 16'(evCnt[0]));
    check("pin level", 16'h0001, {12'h000, timerWaveformPinOut});
    @(posedge sys_clk);
    capLevel[1] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(5'h08, 16'h0003);
    check("capture events", 16'h0001, 16'(evCnt[1]));
    check("pin oe", 16'h000d, {12'h000, timerWaveformPinOe});
    @(posedge sys_clk);
    sleepMode <= 1'b1;
    sleepClockStop <= 1'b1;
    pulse(2);
    @(posedge sys_clk);
    sleepMode <= 1'b0;
    sleepClockStop <= 1'b0;
    rd(5'h03, 16'h0003);
    pulse(1);
    rd(5'h03, 16'h0004);
    @(posedge sys_clk);
    debugMode <= 1'b1;
    pulse(1);
    rd(5'h03, 16'h0004);
    wr(5'h00, 16'h0081);
    pulse(3);
    rd(5'h03, 16'h0005);
    lvl(1'b1);
    rd(5'h03, 16'h0006);
    @(posedge sys_clk);
    debugMode <= 1'b0;
    // Switch while the pin is high, so the inverted view starts with a rise
    wr(5'h00, 16'h0003);
    for (int i = 0; i < 5; i++)
      lvl(i[0]);
    rd(5'h03, 16'h0007);
    lvl(1'b1);
    rd(5'h03, 16'h0007);
    wr(5'h01, 16'h0004);
    lvl(1'b0);
    rd(5'h03, 16'h0007);
    wr(5'h02, 16'h0009);
    wr(5'h01, 16'h0013);
    rd(5'h03, 16'h0009);
    wr(5'h01, 16'h0003);
    rd(5'h03, 16'h0000);
    wr(5'h06, 16'h0a01);
    rd(5'h08, 16'h0000);
    check("capture events", 16'h0002, 16'(evCnt[1]));
    wr(5'h05, 16'h0100);
    repeat (2) @(posedge sys_clk);
    check("pin level", 16'h0001, {12'h000, timerWaveformPinOut});
    wr(5'h05, 16'h0000);
    repeat (2) @(posedge sys_clk);
    check("pin level", 16'h0000, {12'h000, timerWaveformPinOut});
    // One-shot up/down on the undivided internal clock: up to 9, down, stop at 0
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h002f);
    repeat (30) @(posedge sys_clk);
    rd(5'h03, 16'h0000);
    rd(5'h04, 16'h0002);
    check("compare events", 16'h0003, 16'(evCnt[0]));
    check("channel 1 events", 16'h0000, 16'(evCnt[2] + evCnt[3]));
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
